// file: logic/mlpc_pkg.sv
// Package of constants and types for the mode lock and preselection block
package mlpc_pkg;
    // Clock rate and persistence times
    localparam int CLK_HZ         = 100_000_000;
    localparam int LOCK_HOLD_MS   = 20;
    localparam int ACK_HOLD_MS    = 20;
    localparam int HOLD_CYCLES    = (CLK_HZ / 1000) * LOCK_HOLD_MS;
    localparam int ACKH_CYCLES    = (CLK_HZ / 1000) * ACK_HOLD_MS;
    // Brief lamp flash after a refused request, and preselection blink period
    localparam int REFUSE_MS      = 500;
    localparam int REFUSE_CYCLES  = (CLK_HZ / 1000) * REFUSE_MS;
    localparam int BLINK_MS       = 250;
    localparam int BLINK_CYCLES   = (CLK_HZ / 1000) * BLINK_MS;
    // Mode count and status code values
    localparam int NUM_MODES      = 5;
    localparam int MODE_W         = 3;
    localparam logic [3:0] CODE_NO_PERMISSION = 4'h8;
    localparam logic [3:0] CODE_PRESEL_SWITCH = 4'h9;
    localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;
    localparam int PERM_W         = 3;

    typedef enum logic [1:0] {
        MLPC_IDLE,
        MLPC_PENDING
    } mlpc_state_type;
endpackage : mlpc_pkg

// file: logic/mlpc_mode_lock_preselect.sv
// Mode selector with change lock and preselection confirmed by a controller
`timescale 1ns/10ps
// Overview of operation
// (RL1) Accept button press or fallback removal requests
// (RL2) Locked request: flash lamp, no-permission, outputs hold
// (RL3) Lock input high disables change lock
// (RL4) Adopt lock level only after 20 ms
// (RL5) Low lock blocks, ends preselection; high permits
// (RL6) Low ack blocks switching, adopted after 20 ms
// (RL7) Controller keeps 120 ms acknowledge interval
// (RL8) Only latest preselection stays pending
// (RL9) Ack input high disables preselection
// (RL10) Pending: selected lamp steady, preselected flashes
// (RL11) Pending: status shows preselected mode
// (RL12) Restart in last confirmed mode, drop preselection
// (RL13) Confirmation switches outputs to preselected mode
// (RL14) Confirmation: same mode, switched code shown
// (RL15) Confirmation: new lamp steady, old lamp off
// (RL16) Selected mode's button cancels preselection
// (RL17) Re-presented transponder cancels if permission sufficient
// (RL18) Low lock input cancels preselection
// (RL19) Transponder removal never cancels preselection
// (RL20) Synchronise inputs, count persistence cycles
module mlpc_mode_lock_preselect
    import mlpc_pkg::*;
#(
    parameter int HOLD_CYC   = HOLD_CYCLES,
    parameter int ACKH_CYC   = ACKH_CYCLES,
    parameter int REFUSE_CYC = REFUSE_CYCLES,
    parameter int BLINK_CYC  = BLINK_CYCLES
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic                 lockCfg,
    input  wire logic                 preselCfg,
    input  wire logic                 storageCfg,
    input  wire logic                 fallbackCfg,
    input  wire logic [MODE_W-1:0]    storedMode,
    input  wire logic                 lockInputTerminal,
    input  wire logic                 acknowledgeInputTerminal,
    input  wire logic [NUM_MODES-1:0] buttonPress,
    input  wire logic                 tagRemoved,
    input  wire logic [MODE_W-1:0]    fallbackMode,
    input  wire logic                 tagPresented,
    input  wire logic [PERM_W-1:0]    tagPerm,
    input  wire logic [PERM_W-1:0]    removedPerm,
    output logic [NUM_MODES-1:0]      safeModeOutput,
    output logic [NUM_MODES-1:0]      lampOut,
    output logic [3:0]                statusCodeOutputs,
    output logic [MODE_W-1:0]         confirmedMode,
    output logic                      preselPending
);
    localparam int CW = $clog2(HOLD_CYC + ACKH_CYC + REFUSE_CYC
                               + BLINK_CYC + 2);

    // Counts below one would leave the filters and timers stuck
    if (HOLD_CYC < 1 || ACKH_CYC < 1
        || REFUSE_CYC < 1 || BLINK_CYC < 1) begin : g_bad_counts
        $error("mlpc: timing counts must be at least one");
    end

    // One-hot decode of a mode number, used for outputs and lamps
    function automatic logic [NUM_MODES-1:0] mlpc_onehot(
        input logic [MODE_W-1:0] m);
        logic [NUM_MODES-1:0] v;
        v = '0;
        for (int i = 0; i < NUM_MODES; i++) begin
            if (m == MODE_W'(i)) v[i] = 1'b1;
        end
        return v;
    endfunction : mlpc_onehot

    // Two-stage synchronisers; first stage feeds only the second
    logic lockMeta_r, lockSync_r, ackMeta_r, ackSync_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lockMeta_r <= 1'b1;
            lockSync_r <= 1'b1;
            ackMeta_r  <= 1'b1;
            ackSync_r  <= 1'b1;
        end else begin
            lockMeta_r <= lockInputTerminal;            // RL20
            lockSync_r <= lockMeta_r;
            ackMeta_r  <= acknowledgeInputTerminal;
            ackSync_r  <= ackMeta_r;
        end
    end

    // Lock filter: new level adopted after it persisted the hold time
    logic          lockLvl_r;
    logic [CW-1:0] lockCnt_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lockLvl_r <= 1'b1;
            lockCnt_r <= '0;
        end else if (lockSync_r == lockLvl_r) begin
            lockCnt_r <= '0;
        end else if (lockCnt_r == CW'(HOLD_CYC - 1)) begin
            lockLvl_r <= lockSync_r;                    // RL4
            lockCnt_r <= '0;
        end else begin
            lockCnt_r <= lockCnt_r + 1'b1;              // RL20
        end
    end

    // Ack filter: low only after hold time, high taken at once
    logic          ackLvl_r;
    logic [CW-1:0] ackCnt_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ackLvl_r <= 1'b1;
            ackCnt_r <= '0;
        end else if (ackSync_r) begin
            ackLvl_r <= 1'b1;
            ackCnt_r <= '0;
        end else if (!ackLvl_r) begin
            ackCnt_r <= '0;
        end else if (ackCnt_r == CW'(ACKH_CYC - 1)) begin
            ackLvl_r <= 1'b0;                           // RL6
            ackCnt_r <= '0;
        end else begin
            ackCnt_r <= ackCnt_r + 1'b1;
        end
    end

    // Lock active only when configured and terminal level low
    logic locked, preselOn;
    assign locked   = lockCfg && !lockLvl_r;            // RL3 RL5
    // Preselection only when configured and terminal level low
    assign preselOn = preselCfg && !ackLvl_r;           // RL9

    // Request decode: lowest pressed button wins
    logic                reqValid;
    logic [MODE_W-1:0]   reqMode;
    logic                fbReq;
    always_comb begin
        reqValid = 1'b0;
        reqMode  = '0;
        for (int i = NUM_MODES - 1; i >= 0; i--) begin
            if (buttonPress[i]) begin
                reqValid = 1'b1;
                reqMode  = MODE_W'(i);
            end
        end
        fbReq = fallbackCfg && tagRemoved && !reqValid;
        if (fbReq) begin
            reqValid = 1'b1;                            // RL1
            reqMode  = fallbackMode;
        end
    end

    // Mode state machine
    mlpc_state_type      state_r, state_nxt;
    logic [MODE_W-1:0]   selMode_r, preMode_r;
    logic                switched_r, refused_r;
    logic [MODE_W-1:0]   refMode_r;
    logic [CW-1:0]       refCnt_r;
    logic                cancel, confirm, sameBtn;
    logic                restartLoad_r;

    assign sameBtn = reqValid && !fbReq && reqMode == selMode_r; // RL19
    assign cancel  = (state_r == MLPC_PENDING)
                   && (sameBtn                                      // RL16
                       || (fallbackCfg && tagPresented
                           && tagPerm >= removedPerm)               // RL17
                       || locked);                                  // RL18 RL5
    // Confirmation when ack released high; high also turns feature off
    assign confirm = (state_r == MLPC_PENDING) && !cancel && !preselOn;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            MLPC_IDLE:
                if (reqValid && !locked && preselOn && !sameBtn)
                    state_nxt = MLPC_PENDING;
            MLPC_PENDING:
                if (cancel || confirm)
                    state_nxt = MLPC_IDLE;
            default: state_nxt = MLPC_IDLE;
        endcase
    end

    // Restart flag: high for the first cycle after reset only, so that
    // selecting mode zero later never reloads the stored mode
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            restartLoad_r <= 1'b1;
        end else begin
            restartLoad_r <= 1'b0;
        end
    end

    // Selected and preselected modes; restart takes stored mode
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r   <= MLPC_IDLE;                     // RL12
            selMode_r <= MODE_RESET;
            preMode_r <= MODE_RESET;
        end else begin
            state_r <= state_nxt;
            if (restartLoad_r && storageCfg)
                selMode_r <= storedMode;                // RL12
            if (confirm)
                selMode_r <= preMode_r;                 // RL13
            else if (reqValid && !locked && !sameBtn) begin
                if (preselOn && !cancel)
                    preMode_r <= reqMode;               // RL8
                else if (!preselOn && state_r == MLPC_IDLE)
                    selMode_r <= reqMode;
            end
        end
    end

    // Refused request flash timer and switched-code flag
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            refused_r  <= 1'b0;
            refMode_r  <= MODE_RESET;
            refCnt_r   <= '0;
            switched_r <= 1'b0;
        end else begin
            if (reqValid && locked) begin
                refused_r <= 1'b1;                      // RL2
                refMode_r <= reqMode;
                refCnt_r  <= '0;
            end else if (refused_r) begin
                if (refCnt_r == CW'(REFUSE_CYC - 1))
                    refused_r <= 1'b0;
                refCnt_r <= refCnt_r + 1'b1;
            end
            if (confirm)
                switched_r <= 1'b1;                     // RL14
            else if (reqValid)
                switched_r <= 1'b0;
        end
    end

    // Blink phase generator for flashing lamps
    logic [CW-1:0] blinkCnt_r;
    logic          blink_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            blinkCnt_r <= '0;
            blink_r    <= 1'b0;
        end else if (blinkCnt_r == CW'(BLINK_CYC - 1)) begin
            blinkCnt_r <= '0;
            blink_r    <= !blink_r;
        end else begin
            blinkCnt_r <= blinkCnt_r + 1'b1;
        end
    end

    // Registered outputs: mode outputs follow selected mode only
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            safeModeOutput    <= '0;
            lampOut           <= '0;
            statusCodeOutputs <= '0;
            confirmedMode     <= MODE_RESET;
            preselPending     <= 1'b0;
        end else begin
            safeModeOutput <= mlpc_onehot(selMode_r);   // RL2 RL10 RL13
            confirmedMode  <= selMode_r;
            preselPending  <= state_r == MLPC_PENDING;
            if (state_r == MLPC_PENDING) begin
                lampOut <= mlpc_onehot(selMode_r)
                         | (blink_r ? mlpc_onehot(preMode_r) : '0); // RL10
                statusCodeOutputs <= {1'b0, preMode_r};        // RL11
            end else begin
                lampOut <= mlpc_onehot(selMode_r)               // RL15
                         | ((refused_r && blink_r)
                            ? mlpc_onehot(refMode_r) : '0);     // RL2
                if (refused_r)
                    statusCodeOutputs <= CODE_NO_PERMISSION;    // RL2
                else if (switched_r)
                    statusCodeOutputs <= CODE_PRESEL_SWITCH;    // RL14
                else
                    statusCodeOutputs <= {1'b0, selMode_r};
            end
        end
    end

    // Assertions
    a_locked_holds: assert property ( // RL2
        @(posedge ref_clk) disable iff (!rst_n)
        (reqValid && locked && state_r == MLPC_IDLE) |=> $stable(selMode_r))
        else $error("mode changed while locked");
    a_lock_filter: assert property ( // RL4
        @(posedge ref_clk) disable iff (!rst_n)
        $changed(lockLvl_r) |-> lockSync_r == lockLvl_r)
        else $error("lock level adopted wrongly");
    a_ack_filter: assert property ( // RL6
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(ackLvl_r) |-> $past(ackCnt_r) == CW'(ACKH_CYC - 1))
        else $error("ack low adopted too early");
    a_lock_cancel: assert property ( // RL18
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r == MLPC_PENDING && locked) |=> state_r == MLPC_IDLE)
        else $error("low lock kept preselection");
    a_confirm_switch: assert property ( // RL13
        @(posedge ref_clk) disable iff (!rst_n)
        confirm |=> selMode_r == $past(preMode_r) ##1
        safeModeOutput == mlpc_onehot($past(selMode_r)))
        else $error("confirm did not switch outputs");
    a_pend_status: assert property ( // RL11
        @(posedge ref_clk) disable iff (!rst_n)
        state_r == MLPC_PENDING |=> statusCodeOutputs == {1'b0,
        $past(preMode_r)})
        else $error("status not showing preselection");
    a_pend_outputs: assert property ( // RL10
        @(posedge ref_clk) disable iff (!rst_n)
        state_r == MLPC_PENDING && !confirm |=> $stable(selMode_r))
        else $error("outputs moved while pending");
    a_same_cancel: assert property ( // RL16
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r == MLPC_PENDING && sameBtn) |=> state_r == MLPC_IDLE)
        else $error("own button did not cancel");
    a_ack_high_off: assert property ( // RL9
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r == MLPC_IDLE && ackLvl_r) |=> state_r == MLPC_IDLE)
        else $error("preselection with ack high");
    // Timing of the lock filter, not only the level it takes
    a_lock_timing: assert property ( // RL4 RL20
        @(posedge ref_clk) disable iff (!rst_n)
        $changed(lockLvl_r) |-> $past(lockCnt_r) == CW'(HOLD_CYC - 1))
        else $error("lock level adopted before hold time");
    a_refuse_code: assert property ( // RL2
        @(posedge ref_clk) disable iff (!rst_n)
        (reqValid && locked && state_r == MLPC_IDLE)
        |-> ##2 statusCodeOutputs == CODE_NO_PERMISSION)
        else $error("refused request without no-permission code");
    a_switch_code: assert property ( // RL14
        @(posedge ref_clk) disable iff (!rst_n)
        (confirm && !refused_r) |-> ##2 statusCodeOutputs == CODE_PRESEL_SWITCH)
        else $error("confirm without switched code");
    a_confirm_lamp: assert property ( // RL15
        @(posedge ref_clk) disable iff (!rst_n)
        (confirm && !refused_r)
        |-> ##2 lampOut == mlpc_onehot($past(preMode_r, 2)))
        else $error("lamps wrong after confirm");
    a_pend_lamp: assert property ( // RL10
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r == MLPC_PENDING && !blink_r)
        |=> lampOut == mlpc_onehot($past(selMode_r)))
        else $error("selected lamp not steady while pending");
    a_remove_keeps: assert property ( // RL19 RL8
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r == MLPC_PENDING && fbReq && preselOn && !locked
         && !tagPresented)
        |=> state_r == MLPC_PENDING && preMode_r == $past(fallbackMode))
        else $error("removal cancelled or lost preselection");
    a_restart_mode: assert property ( // RL12
        @(posedge ref_clk) disable iff (!rst_n)
        (restartLoad_r && storageCfg && !reqValid)
        |=> selMode_r == $past(storedMode))
        else $error("stored mode not taken at restart");
endmodule : mlpc_mode_lock_preselect

// file: test/mlpc_ctrl_model.sv
// Controller model driving the lock and acknowledge pins
`timescale 1ns/10ps
module mlpc_ctrl_model #(
    parameter int MIN_HOLD = 20,
    parameter int ACK_GAP  = 120
) (
    input  wire logic ref_clk,
    input  wire logic lockReq,
    input  wire logic ackReq,
    output logic      lockInputTerminal,
    output logic      acknowledgeInputTerminal
);
    int lockCnt = 0;
    int ackCnt  = 0;
    // Both pins idle high, which leaves both features switched off
    initial begin
        lockInputTerminal = 1'b1;
        acknowledgeInputTerminal = 1'b1;
    end
    // Lock level is never changed before it has stood its minimum time
    always @(negedge ref_clk) begin
        lockCnt <= lockCnt + 1;
        if (lockReq !== lockInputTerminal && lockCnt >= MIN_HOLD) begin
            lockInputTerminal <= lockReq;
            lockCnt <= 0;
        end
    end
    // Ack high stands the hold time before going low; a confirm waits the full interval
    always @(negedge ref_clk) begin
        ackCnt <= ackCnt + 1;
        if (ackReq !== acknowledgeInputTerminal &&
            ackCnt >= (ackReq ? ACK_GAP : MIN_HOLD)) begin
            acknowledgeInputTerminal <= ackReq;
            ackCnt <= 0;
        end
    end
endmodule : mlpc_ctrl_model

// file: test/mlpc_mode_lock_preselect_tb_top.sv
// Testbench for the mode lock and preselection block
`timescale 1ns/10ps
module mlpc_mode_lock_preselect_tb_top;
    import mlpc_pkg::*;
    localparam int HOLD = 20;
    localparam int BLK  = 10;
    localparam int W    = 50;
    logic ref_clk = 0, rst_n = 0, lockReq = 1, ackReq = 1;
    logic storageCfg = 0, fallbackCfg = 0, lockCfg = 1;
    logic tagRemoved = 0, tagPresented = 0;
    logic [MODE_W-1:0] storedMode = 3'h0, fallbackMode = 3'h0;
    logic [PERM_W-1:0] tagPerm = 3'h0, removedPerm = 3'h0;
    logic [NUM_MODES-1:0] buttonPress = 5'h00, safeModeOutput, lampOut;
    logic [3:0] statusCodeOutputs;
    logic [MODE_W-1:0] confirmedMode;
    logic preselPending, lockInputTerminal, acknowledgeInputTerminal;
    int n_fail = 0;
    int check_count = 0;
    // Short counts keep the run brief; expectations follow from these
    mlpc_mode_lock_preselect #(.HOLD_CYC(HOLD), .ACKH_CYC(HOLD),
        .REFUSE_CYC(40), .BLINK_CYC(BLK)) u_mlpc_mode_lock_preselect (
        .ref_clk(ref_clk), .rst_n(rst_n), .lockCfg(lockCfg),
        .preselCfg(1'b1), .storageCfg(storageCfg),
        .fallbackCfg(fallbackCfg), .storedMode(storedMode),
        .lockInputTerminal(lockInputTerminal),
        .acknowledgeInputTerminal(acknowledgeInputTerminal),
        .buttonPress(buttonPress), .tagRemoved(tagRemoved),
        .fallbackMode(fallbackMode), .tagPresented(tagPresented),
        .tagPerm(tagPerm), .removedPerm(removedPerm),
        .safeModeOutput(safeModeOutput), .lampOut(lampOut),
        .statusCodeOutputs(statusCodeOutputs),
        .confirmedMode(confirmedMode), .preselPending(preselPending));
    // Acknowledge interval scaled like the 20 ms hold: six holds
    mlpc_ctrl_model #(.MIN_HOLD(HOLD), .ACK_GAP(6 * HOLD)) u_mlpc_ctrl_model (
        .ref_clk(ref_clk), .lockReq(lockReq), .ackReq(ackReq),
        .lockInputTerminal(lockInputTerminal),
        .acknowledgeInputTerminal(acknowledgeInputTerminal));
    // 100 MHz clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk
    // One-cycle button pulse, then time for the registered answer
    task automatic press(input int i);
        buttonPress = 5'h01 << i;
        cyc(1);
        buttonPress = 5'h00;
        cyc(4);
    endtask : press
    // A lamp blinks if both levels turn up over a few blink periods
    task automatic blinks(input int i, input string msg);
        logic s0;
        logic s1;
        s0 = 0;
        s1 = 0;
        repeat (3 * BLK) begin
            cyc(1);
            s0 |= (lampOut[i] === 1'b0);
            s1 |= (lampOut[i] === 1'b1);
        end
        chk(s0 && s1, msg);
    endtask : blinks
    // Bounded wait on the pending flag; a timeout ends the run
    task automatic wait_pend(input logic v);
        int k;
        k = 0;
        while (preselPending !== v && k < 100) begin
            cyc(1);
            k++;
        end
        if (k >= 100) begin
            n_fail++;
            end_of_test();
        end
    endtask : wait_pend
    task automatic t_lock;
        lockReq = 0;
        cyc(W);
        press(3);
        chk(statusCodeOutputs === CODE_NO_PERMISSION, "no code");
        chk(safeModeOutput === 5'h01, "outputs moved");
        blinks(3, "refused lamp");
        lockCfg = 0;
        press(2);
        chk(confirmedMode === 3'h2, "lock not configured");
        lockCfg = 1;
        lockReq = 1;
        cyc(W);
        press(1);
        chk(confirmedMode === 3'h1, "mode 1");
        chk(safeModeOutput === 5'h02, "outputs 1");
        $display("lock test done");
    endtask : t_lock
    task automatic t_presel;
        ackReq = 0;
        cyc(W);
        press(2);
        chk(preselPending === 1'b1, "not pending");
        chk(statusCodeOutputs === 4'h2, "status 2");
        chk(safeModeOutput === 5'h02 && lampOut[1] === 1'b1, "sel");
        blinks(2, "presel lamp");
        press(4);
        chk(statusCodeOutputs === 4'h4, "latest");
        ackReq = 1;
        wait_pend(1'b0);
        cyc(3);
        chk(safeModeOutput === 5'h10, "confirm");
        chk(statusCodeOutputs === CODE_PRESEL_SWITCH, "code");
        chk(lampOut[4] === 1'b1 && lampOut[1] === 1'b0, "lamps");
        $display("preselection test done");
    endtask : t_presel
    task automatic t_cancel;
        ackReq = 0;
        cyc(W);
        press(0);
        press(4);
        chk(preselPending === 1'b0, "button cancel");
        press(1);
        chk(preselPending === 1'b1, "pending 1");
        lockReq = 0;
        wait_pend(1'b0);
        chk(safeModeOutput === 5'h10, "kept 4");
        lockReq = 1;
        cyc(W);
        $display("cancel test done");
    endtask : t_cancel
    task automatic t_tag;
        fallbackCfg = 1;
        fallbackMode = 3'h3;
        removedPerm = 3'h3;
        press(2);
        tagRemoved = 1;
        cyc(1);
        tagRemoved = 0;
        cyc(4);
        chk(preselPending === 1'b1, "removal");
        chk(statusCodeOutputs === 4'h3, "fallback");
        for (int b = 0; b < 2; b++) begin
            tagPerm = (b == 0) ? 3'h2 : 3'h3;
            tagPresented = 1;
            cyc(1);
            tagPresented = 0;
            cyc(4);
            chk(preselPending === (b == 0), "present");
        end
        $display("transponder test done");
    endtask : t_tag
    task automatic t_restart;
        storageCfg = 1;
        storedMode = 3'h2;
        press(1);
        rst_n = 0;
        cyc(2);
        rst_n = 1;
        cyc(5);
        chk(confirmedMode === 3'h2, "stored");
        chk(safeModeOutput === 5'h04, "stored out");
        chk(preselPending === 1'b0, "presel kept");
        $display("restart test done");
    endtask : t_restart
    // Main sequence after a five-cycle reset
    initial begin
        cyc(5);
        rst_n = 1;
        cyc(5);
        chk(safeModeOutput === 5'h01, "reset mode");
        chk(confirmedMode === MODE_RESET, "reset sel");
        t_lock();
        t_presel();
        t_cancel();
        t_tag();
        t_restart();
        end_of_test();
    end
endmodule : mlpc_mode_lock_preselect_tb_top
